// File: design/bcs_sequencer.sv
// Battery charge state sequencer: state machine, status words, interrupt.
// Assumes measurements come from logic on the same clock and the battery
// presence level comes from a pin; software uses the plain register port.
//
// Overview of operation
// - Power-up waits two minutes, reporting code eleven
// - After the wait, charging starts unless faulted or locked out
// - Battery temperature is processor temperature minus thirty
// - Eleven to forty-five degrees: fast charge
// - Above forty-five to sixty: hot slow charge
// - Zero to ten degrees: cold slow charge
// - Charge timeout: code three, five-minute pause, retry
// - Above sixty: stop until sixty or less
// - Below zero: stop until zero or more
// - Missing battery at power-up: code seven, locked
// - Low voltage at power-up: code ten, locked
// - Fault flag when absent or below 2.5 V
// - Full charge: code zero, then discharge wait
// - Discharge wait recharges below four volts
// - Hot full charge: hold 4.1 V until allowed
// - Status words: temperature, state, current, voltage
// - Voltage reading valid only while not charging
// - Power-up restarts sequence from waiting
`timescale 1ns/1ps
`default_nettype none
`include "bcs_consts.svh"

module bcs_sequencer #(
    parameter logic [47:0] WAIT_CYCLES = 48'(`BCS_WAIT_MIN * `BCS_SEC_PER_MIN * `BCS_CLK_HZ),
    parameter logic [47:0] RETRY_CYCLES = 48'(`BCS_RETRY_MIN * `BCS_SEC_PER_MIN * `BCS_CLK_HZ),
    parameter logic [47:0] NORMAL_LIMIT_CYCLES = 48'(`BCS_NORMAL_LIMIT_HRS * `BCS_SEC_PER_HR * `BCS_CLK_HZ),
    parameter logic [47:0] SLOW_LIMIT_CYCLES = 48'(`BCS_SLOW_LIMIT_HRS * `BCS_SEC_PER_HR * `BCS_CLK_HZ)
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire bcs_pkg::bcs_meas_t meas,
    input wire logic battery_present,
    input wire logic [3:0] address,
    input wire logic [15:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output bcs_pkg::bcs_charge_cmd_t charge_cmd_reg,
    output logic battery_fault_flag_reg,
    output logic [15:0] read_data_reg,
    output logic irq_reg
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bcs_pkg::bcs_state_t state_reg;
    bcs_pkg::bcs_state_t state_next;
    bcs_pkg::bcs_charge_cmd_t cmd_next;
    logic signed [15:0] batt_temp;
    logic present_sync;
    logic timer_expired;
    logic timer_start;
    logic fault_next;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_events;
    logic status_read;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Band choice from battery temperature; also used for lockout exits
    function automatic bcs_pkg::bcs_state_t select_band(input logic signed [15:0] tb);
        if (tb > `BCS_TB_HOT_LOCK) begin
            select_band = bcs_pkg::BCS_TOO_HOT;
        end else if (tb > `BCS_TB_HOT_ABOVE) begin
            select_band = bcs_pkg::BCS_HOT;
        end else if (tb >= `BCS_TB_NORMAL_MIN) begin
            select_band = bcs_pkg::BCS_NORMAL;
        end else if (tb >= `BCS_TB_COLD_MIN) begin
            select_band = bcs_pkg::BCS_COLD;
        end else begin
            select_band = bcs_pkg::BCS_TOO_COLD;
        end
    endfunction : select_band

    // Charger command that each state asks for
    function automatic bcs_pkg::bcs_charge_cmd_t cmd_of(input bcs_pkg::bcs_state_t st);
        cmd_of = '0;
        case (st)
            bcs_pkg::BCS_NORMAL: begin
                cmd_of = {1'b1, `BCS_MA_FAST, `BCS_MV_FULL};
            end
            bcs_pkg::BCS_HOT, bcs_pkg::BCS_FINAL_HOT: begin
                cmd_of = {1'b1, `BCS_MA_SLOW, `BCS_MV_HOT_FULL};
            end
            bcs_pkg::BCS_COLD: begin
                cmd_of = {1'b1, `BCS_MA_SLOW, `BCS_MV_FULL};
            end
            default: begin
                cmd_of = '0;
            end
        endcase
    endfunction : cmd_of

    // Interval loaded on entry to each state
    function automatic logic [47:0] timer_load(input bcs_pkg::bcs_state_t st);
        case (st)
            bcs_pkg::BCS_NORMAL: timer_load = NORMAL_LIMIT_CYCLES;
            bcs_pkg::BCS_HOT, bcs_pkg::BCS_COLD: timer_load = SLOW_LIMIT_CYCLES;
            bcs_pkg::BCS_RETRY: timer_load = RETRY_CYCLES;
            bcs_pkg::BCS_WAITING: timer_load = WAIT_CYCLES;
            default: timer_load = 48'h000000000000;
        endcase
    endfunction : timer_load

    // True in the states that drive the charger toward a target
    function automatic logic is_charging(input bcs_pkg::bcs_state_t st);
        is_charging = (st == bcs_pkg::BCS_NORMAL) || (st == bcs_pkg::BCS_HOT) || (st == bcs_pkg::BCS_COLD);
    endfunction : is_charging

    // ------------------------------------------------------------
    // Inputs and timer
    // ------------------------------------------------------------

    // Battery temperature derived from the processor sensor
    assign batt_temp = $signed(meas.proc_temp) - `BCS_TB_OFFSET;

    // Presence level comes from a pin
    bcs_sync u_present_sync (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .din(battery_present),
        .dout(present_sync)
    );

    // One timer serves wait, charge limit and retry pause
    assign timer_start = (state_next != state_reg);

    bcs_interval_timer #(
        .RESET_LOAD(WAIT_CYCLES)
    ) u_timer (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .start(timer_start),
        .load(timer_load(state_next)),
        .expired(timer_expired)
    );

    // ------------------------------------------------------------
    // Charge state machine
    // ------------------------------------------------------------

    // Next state; lockouts are checked before completion and timeout
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            bcs_pkg::BCS_WAITING: begin
                if (timer_expired) begin
                    if (!present_sync) begin
                        state_next = bcs_pkg::BCS_NO_BATTERY;
                    end else if (meas.voltage_mv < `BCS_MV_FAULT) begin
                        state_next = bcs_pkg::BCS_LOW_VOLTAGE;
                    end else begin
                        state_next = select_band(batt_temp);
                    end
                end
            end
            bcs_pkg::BCS_NORMAL, bcs_pkg::BCS_HOT, bcs_pkg::BCS_COLD: begin
                if (batt_temp > `BCS_TB_HOT_LOCK) begin
                    state_next = bcs_pkg::BCS_TOO_HOT;
                end else if (batt_temp < `BCS_TB_COLD_MIN) begin
                    state_next = bcs_pkg::BCS_TOO_COLD;
                end else if (meas.voltage_mv >= charge_cmd_reg.target_mv) begin
                    // Hot charge stops short of full and holds there
                    if (state_reg == bcs_pkg::BCS_HOT) begin
                        state_next = bcs_pkg::BCS_FINAL_HOT;
                    end else begin
                        state_next = bcs_pkg::BCS_FINAL_FULL;
                    end
                end else if (timer_expired) begin
                    state_next = bcs_pkg::BCS_RETRY;
                end
            end
            bcs_pkg::BCS_RETRY: begin
                if (timer_expired) begin
                    state_next = select_band(batt_temp);
                end
            end
            bcs_pkg::BCS_TOO_HOT: begin
                if (batt_temp <= `BCS_TB_HOT_LOCK) begin
                    state_next = select_band(batt_temp);
                end
            end
            bcs_pkg::BCS_TOO_COLD: begin
                if (batt_temp >= `BCS_TB_COLD_MIN) begin
                    state_next = select_band(batt_temp);
                end
            end
            bcs_pkg::BCS_FINAL_FULL: begin
                state_next = bcs_pkg::BCS_DISCHARGE_WAIT;
            end
            bcs_pkg::BCS_DISCHARGE_WAIT: begin
                if (meas.voltage_mv < `BCS_MV_RECHARGE) begin
                    state_next = select_band(batt_temp);
                end
            end
            bcs_pkg::BCS_FINAL_HOT: begin
                // Hold 4.1 V until the temperature leaves the hot band
                if (select_band(batt_temp) != bcs_pkg::BCS_HOT) begin
                    state_next = select_band(batt_temp);
                end
            end
            bcs_pkg::BCS_NO_BATTERY, bcs_pkg::BCS_LOW_VOLTAGE: begin
                state_next = state_reg;
            end
            default: begin
                state_next = bcs_pkg::BCS_WAITING;
            end
        endcase
    end

    // State register; only a reset leaves the locked error states
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= bcs_pkg::BCS_WAITING;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Charger command registered alongside the state it belongs to
    assign cmd_next = cmd_of(state_next);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            charge_cmd_reg <= '0;
        end else if (ce) begin
            charge_cmd_reg <= cmd_next;
        end
    end

    // Fault flag follows the live condition and the locked errors
    assign fault_next = !present_sync || (meas.voltage_mv < `BCS_MV_FAULT) ||
                        (state_next == bcs_pkg::BCS_NO_BATTERY) || (state_next == bcs_pkg::BCS_LOW_VOLTAGE);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            battery_fault_flag_reg <= 1'b0;
        end else if (ce) begin
            battery_fault_flag_reg <= fault_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------

    // Events: state change, fault rise, retry entry, charge complete
    assign irq_events = {
        (state_next != state_reg) && ((state_next == bcs_pkg::BCS_FINAL_FULL) ||
                                      (state_next == bcs_pkg::BCS_FINAL_HOT)),
        (state_next != state_reg) && (state_next == bcs_pkg::BCS_RETRY),
        fault_next && !battery_fault_flag_reg,
        (state_next != state_reg)
    };
    assign status_read = read_strobe && (address == `BCS_REG_IRQ_STATUS);

    // Read clears, but an event in the same cycle stays set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_status_reg <= `BCS_IRQ_RESET;
        end else if (ce) begin
            irq_status_reg <= (status_read ? `BCS_IRQ_RESET : irq_status_reg) | irq_events;
        end
    end

    // Mask written by software gates the single interrupt line
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_mask_reg <= `BCS_IRQ_RESET;
        end else if (ce && write_strobe && address == `BCS_REG_IRQ_MASK) begin
            irq_mask_reg <= write_data[3:0];
        end
    end

    // Registered so the output comes straight from a flop
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------

    // Data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            read_data_reg <= 16'h0000;
        end else if (ce) begin
            read_data_reg <= 16'h0000;
            if (read_strobe) begin
                case (address)
                    `BCS_REG_PROC_TEMP: read_data_reg <= meas.proc_temp;
                    `BCS_REG_STATE_CODE: read_data_reg <= {12'h000, state_reg};
                    `BCS_REG_CURRENT: read_data_reg <= meas.current_ma;
                    `BCS_REG_VOLTAGE: read_data_reg <= meas.voltage_mv;
                    `BCS_REG_FLAGS: begin
                        // Voltage is trustworthy only with the charger idle
                        read_data_reg <= {13'h0000, charge_cmd_reg.enable,
                                          !charge_cmd_reg.enable, battery_fault_flag_reg};
                    end
                    `BCS_REG_IRQ_STATUS: read_data_reg <= {12'h000, irq_status_reg};
                    `BCS_REG_IRQ_MASK: read_data_reg <= {12'h000, irq_mask_reg};
                    default: read_data_reg <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    a_powerup_wait: assert property (@(posedge clock) disable iff (!resetn)
        $rose(resetn) |-> (state_reg == bcs_pkg::BCS_WAITING) && !charge_cmd_reg.enable)
        else $error("power-up did not start in waiting");

    a_wait_exit_charge: assert property (@(posedge clock) disable iff (!resetn)
        (ce && state_reg == bcs_pkg::BCS_WAITING && timer_expired && present_sync &&
         meas.voltage_mv >= `BCS_MV_FAULT && batt_temp >= `BCS_TB_NORMAL_MIN &&
         batt_temp <= `BCS_TB_HOT_ABOVE) |=> (state_reg == bcs_pkg::BCS_NORMAL) && charge_cmd_reg.enable)
        else $error("wait end did not start normal charge");

    a_normal_cmd: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == bcs_pkg::BCS_NORMAL) |->
        charge_cmd_reg.enable && charge_cmd_reg.current_ma == `BCS_MA_FAST && charge_cmd_reg.target_mv == `BCS_MV_FULL)
        else $error("normal charge command wrong");

    a_hot_lockout: assert property (@(posedge clock) disable iff (!resetn)
        (ce && is_charging(state_reg) && batt_temp > `BCS_TB_HOT_LOCK) |=>
        (state_reg == bcs_pkg::BCS_TOO_HOT) && !charge_cmd_reg.enable)
        else $error("overheat did not stop charging");

    a_cold_lockout: assert property (@(posedge clock) disable iff (!resetn)
        (ce && is_charging(state_reg) && batt_temp < `BCS_TB_COLD_MIN) |=>
        (state_reg == bcs_pkg::BCS_TOO_COLD) && !charge_cmd_reg.enable)
        else $error("cold did not stop charging");

    a_retry_cause: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == bcs_pkg::BCS_RETRY && $past(state_reg) != bcs_pkg::BCS_RETRY) |->
        $past(timer_expired) && is_charging($past(state_reg)) && !charge_cmd_reg.enable)
        else $error("retry entered without charge timeout");

    a_error_locked: assert property (@(posedge clock) disable iff (!resetn)
        (state_reg == bcs_pkg::BCS_NO_BATTERY || state_reg == bcs_pkg::BCS_LOW_VOLTAGE) |->
        battery_fault_flag_reg && !charge_cmd_reg.enable ##1 $stable(state_reg))
        else $error("error state not locked with fault flag");

    a_full_to_disch: assert property (@(posedge clock) disable iff (!resetn)
        (ce && state_reg == bcs_pkg::BCS_FINAL_FULL) |=> (state_reg == bcs_pkg::BCS_DISCHARGE_WAIT))
        else $error("full charge did not move to discharge wait");

    a_fault_flag: assert property (@(posedge clock) disable iff (!resetn)
        (ce && (!present_sync || meas.voltage_mv < `BCS_MV_FAULT)) |=> battery_fault_flag_reg)
        else $error("fault flag not set");

endmodule : bcs_sequencer

`default_nettype wire

// File: shared/bcs_consts.svh
// Named constants of the battery charge state sequencer.
// Assumes a 20 MHz system clock; included by its bare name.
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and interval lengths
// ----------------------------------------------------------------
`define BCS_CLK_HZ 64'd20000000
`define BCS_SEC_PER_MIN 64'd60
`define BCS_SEC_PER_HR 64'd3600
`define BCS_WAIT_MIN 64'd2
`define BCS_RETRY_MIN 64'd5
`define BCS_NORMAL_LIMIT_HRS 64'd8
`define BCS_SLOW_LIMIT_HRS 64'd40

// ----------------------------------------------------------------
// Temperature thresholds, degrees Celsius, signed
// ----------------------------------------------------------------
`define BCS_TB_OFFSET 16'sh001E
`define BCS_TB_HOT_LOCK 16'sh003C
`define BCS_TB_HOT_ABOVE 16'sh002D
`define BCS_TB_NORMAL_MIN 16'sh000B
`define BCS_TB_COLD_MIN 16'sh0000

// ----------------------------------------------------------------
// Voltages in mV and currents in mA
// ----------------------------------------------------------------
`define BCS_MV_FULL 16'h1068
`define BCS_MV_HOT_FULL 16'h1004
`define BCS_MV_RECHARGE 16'h0FA0
`define BCS_MV_FAULT 16'h09C4
`define BCS_MA_FAST 16'h0064
`define BCS_MA_SLOW 16'h0014

// ----------------------------------------------------------------
// Register word indices and fields
// ----------------------------------------------------------------
`define BCS_REG_PROC_TEMP 4'h0
`define BCS_REG_STATE_CODE 4'h1
`define BCS_REG_CURRENT 4'h2
`define BCS_REG_VOLTAGE 4'h3
`define BCS_REG_FLAGS 4'h4
`define BCS_REG_IRQ_STATUS 4'h5
`define BCS_REG_IRQ_MASK 4'h6
`define BCS_IRQ_RESET 4'h0

`endif

// File: shared/bcs_pkg.sv
// Types shared by the battery charge state sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package bcs_pkg;

    // ------------------------------------------------------------
    // Charge states; each code is the reported state code
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        BCS_FINAL_FULL = 4'b0000,
        BCS_NORMAL = 4'b0001,
        BCS_HOT = 4'b0010,
        BCS_RETRY = 4'b0011,
        BCS_TOO_HOT = 4'b0100,
        BCS_COLD = 4'b0101,
        BCS_TOO_COLD = 4'b0110,
        BCS_NO_BATTERY = 4'b0111,
        BCS_FINAL_HOT = 4'b1000,
        BCS_LOW_VOLTAGE = 4'b1010,
        BCS_WAITING = 4'b1011,
        BCS_DISCHARGE_WAIT = 4'b1100
    } bcs_state_t;

    // Measurements arriving from the sensing logic
    typedef struct packed {
        logic [15:0] proc_temp;
        logic [15:0] current_ma;
        logic [15:0] voltage_mv;
    } bcs_meas_t;

    // Command toward the charger circuit
    typedef struct packed {
        logic enable;
        logic [15:0] current_ma;
        logic [15:0] target_mv;
    } bcs_charge_cmd_t;

endpackage : bcs_pkg

// File: design/bcs_sync.sv
// Two-stage synchroniser for one level from a pin.
// Assumes the level is slow against the system clock.
`timescale 1ns/1ps
`default_nettype none

module bcs_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic din,
    output logic dout
);

    logic meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge resetn) begin
        // Resets to the fitted level, so no false fault edge follows reset
        if (!resetn) begin
            meta_reg <= 1'b1;
            dout <= 1'b1;
        end else if (ce) begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end

endmodule : bcs_sync

`default_nettype wire

// File: design/bcs_interval_timer.sv
// Down-counting interval timer, restarted by a one-cycle start.
// Assumes the load value is steady in the start cycle.
`timescale 1ns/1ps
`default_nettype none

module bcs_interval_timer #(
    parameter logic [47:0] RESET_LOAD = 48'h000000000001
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [47:0] load,
    output logic expired
);

    logic [47:0] count_reg;

    // Runs from reset so the power-up wait needs no start pulse
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= RESET_LOAD;
        end else if (ce) begin
            if (start) begin
                count_reg <= load;
            end else if (count_reg != 48'h000000000000) begin
                count_reg <= count_reg - 48'h000000000001;
            end
        end
    end

    // Level until the next start
    assign expired = (count_reg == 48'h000000000000);

endmodule : bcs_interval_timer

`default_nettype wire

// File: verification/bcs_batt_model.sv
// Model of the backup cell and its charger, answering the charge command.
// Assumes the bench sets temperature, starting voltage, stall and drain.
`timescale 1ns/1ps
`default_nettype none

module bcs_batt_model (
    input wire logic clock,
    input wire bcs_pkg::bcs_charge_cmd_t cmd,
    input wire logic load,
    input wire logic [15:0] load_mv,
    input wire logic [15:0] temp,
    input wire logic stall,
    input wire logic drain,
    output bcs_pkg::bcs_meas_t meas
);
    // ------------------------------------------------------------
    // Cell voltage
    // ------------------------------------------------------------
    logic [15:0] mv_reg;

    // Steps land exactly on both targets; a stalled cell never completes
    always_ff @(posedge clock) begin
        if (load) mv_reg <= load_mv;
        else if (cmd.enable && !stall && mv_reg < cmd.target_mv) mv_reg <= mv_reg + 16'h0014;
        else if (!cmd.enable && drain) mv_reg <= mv_reg - 16'h000A;
    end

    // Current flows only while the charger is enabled
    assign meas = {temp, (cmd.enable ? cmd.current_ma : 16'h0000), mv_reg};
endmodule : bcs_batt_model

`default_nettype wire

// File: verification/tb_battery_charge_state_sequencer.sv
// Self-checking bench for the charge state sequencer.
// Assumes shortened interval parameters and the cell model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module tb_battery_charge_state_sequencer;
    logic clock = 0, resetn = 0, ce = 1, present = 1, write_strobe = 0, read_strobe = 0;
    logic load = 1, stall = 0, drain = 0;
    logic fault, irq;
    logic [3:0] address = 4'h0;
    logic [15:0] write_data = 16'h0000, load_mv = 16'h0ED8, temp = 16'h0037, read_data;
    logic [52:0] band [7] = '{{16'h005A, 4'h2, 33'h100141004}, {16'h005B, 4'h4, 33'h000000000},
        {16'h004B, 4'h1, 33'h100641068}, {16'h0029, 4'h1, 33'h100641068}, {16'h0028, 4'h5, 33'h100141068},
        {16'h001E, 4'h5, 33'h100141068}, {16'h001D, 4'h6, 33'h000000000}};
    int fail_count = 0, checks = 0, cyc = 0;
    bcs_pkg::bcs_meas_t meas;
    bcs_pkg::bcs_charge_cmd_t cmd;

    always #25 clock = ~clock;

    bcs_sequencer #(.WAIT_CYCLES(48'h14), .RETRY_CYCLES(48'h0A), .NORMAL_LIMIT_CYCLES(48'h32),
        .SLOW_LIMIT_CYCLES(48'h50)) dut_u (.clock(clock), .resetn(resetn), .ce(ce), .meas(meas),
        .battery_present(present), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .charge_cmd_reg(cmd),
        .battery_fault_flag_reg(fault), .read_data_reg(read_data), .irq_reg(irq));

    bcs_batt_model model_u (.clock(clock), .cmd(cmd), .load(load), .load_mv(load_mv), .temp(temp),
        .stall(stall), .drain(drain), .meas(meas));

    // ------------------------------------------------------------
    // Bus and sequencing tasks
    // ------------------------------------------------------------
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        read_strobe <= 1'b1;
        address <= a;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 `CHK(read_data, e)
    endtask : rd_chk

    task automatic st(input logic [3:0] code);
        rd_chk(`BCS_REG_STATE_CODE, {12'h000, code});
    endtask : st

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        write_strobe <= 1'b1;
        address <= a;
        write_data <= d;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask : wr

    // Power cycle: every start must report waiting again
    task automatic boot(input logic p, input logic [15:0] t, input logic [15:0] mv);
        @(posedge clock);
        resetn <= 1'b0;
        present <= p;
        temp <= t;
        load_mv <= mv;
        load <= 1'b1;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        load <= 1'b0;
        st(4'hB);
    endtask : boot

    // Bounded waits on the charger command and on the cell voltage
    task automatic wait_en(input logic v);
        for (int i = 0; i < 200 && cmd.enable !== v; i++) @(posedge clock);
        #1;
        if (cmd.enable !== v) begin
            fail_count++;
            $display("ERROR %0t: charger enable wait ran out", $time);
        end
    endtask : wait_en

    task automatic wait_mv(input logic [15:0] v);
        for (int i = 0; i < 200 && meas.voltage_mv !== v; i++) @(posedge clock);
        #1;
        if (meas.voltage_mv !== v) begin
            fail_count++;
            $display("ERROR %0t: cell voltage wait ran out", $time);
        end
    endtask : wait_mv

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        // Normal charge to full, discharge wait, recharge, timeout
        boot(1'b1, 16'h0037, 16'h0ED8);
        rd_chk(`BCS_REG_FLAGS, 16'h0002);
        rd_chk(`BCS_REG_PROC_TEMP, 16'h0037);
        rd_chk(`BCS_REG_VOLTAGE, 16'h0ED8);
        rd_chk(`BCS_REG_IRQ_MASK, 16'h0000);
        wr(`BCS_REG_IRQ_MASK, 16'h0008);
        wait_en(1'b1);
        st(4'h1);
        `CHK(cmd, 33'h100641068)
        rd_chk(`BCS_REG_CURRENT, 16'h0064);
        rd_chk(`BCS_REG_FLAGS, 16'h0004);
        `CHK(irq, 1'b0)
        wait_en(1'b0);
        st(4'hC);
        `CHK(irq, 1'b1)
        rd_chk(`BCS_REG_IRQ_STATUS, 16'h0009);
        rd_chk(`BCS_REG_IRQ_STATUS, 16'h0000);
        `CHK(irq, 1'b0)
        rd_chk(4'hF, 16'h0000);
        @(posedge clock) drain <= 1'b1;
        wait_en(1'b1);
        @(posedge clock) drain <= 1'b0;
        st(4'h1);
        @(posedge clock) stall <= 1'b1;
        wait_en(1'b0);
        st(4'h3);
        wait_en(1'b1);
        st(4'h1);
        rd_chk(`BCS_REG_IRQ_STATUS, 16'h0005);
        $display("end normal");
        // Hot charge holds its final voltage until the band changes
        @(posedge clock) stall <= 1'b0;
        boot(1'b1, 16'h0050, 16'h0ED8);
        wait_mv(16'h1004);
        st(4'h8);
        `CHK(cmd, 33'h100141004)
        @(posedge clock) temp <= 16'h0037;
        st(4'h1);
        $display("end hot");
        // Temperature bands at their edges
        @(posedge clock) stall <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            boot(1'b1, band[i][52:37], 16'h0ED8);
            repeat (25) @(posedge clock);
            st(band[i][36:33]);
            `CHK(cmd, band[i][32:0])
        end
        @(posedge clock) temp <= 16'h0037;
        wait_en(1'b1);
        st(4'h1);
        // Lockouts taken from a running charge
        @(posedge clock) temp <= 16'h005B;
        st(4'h4);
        @(posedge clock) temp <= 16'h0037;
        wait_en(1'b1);
        @(posedge clock) temp <= 16'h001D;
        st(4'h6);
        $display("end bands");
        // Power-up faults lock the sequencer
        boot(1'b0, 16'h0037, 16'h0ED8);
        repeat (25) @(posedge clock);
        st(4'h7);
        `CHK(fault, 1'b1)
        rd_chk(`BCS_REG_IRQ_STATUS, 16'h0003);
        boot(1'b1, 16'h0037, 16'h07D0);
        repeat (25) @(posedge clock);
        st(4'hA);
        rd_chk(`BCS_REG_FLAGS, 16'h0003);
        `CHK(cmd.enable, 1'b0)
        $display("end faults");
        finish_test();
    end
endmodule : tb_battery_charge_state_sequencer

`default_nettype wire
